// [dv/psk_link_keeper_tb.sv]
/*
 * Self-checking bench for the power state link keeper.
 * Assumes psk_pkg and the transceiver model are compiled first.
 */
`timescale 1ns/1ns
`default_nettype none

module psk_link_keeper_tb;
    import psk_pkg::*;

    logic         ref_clk_in, rst_in, wr_en, rd_en, aux, spd, fail, link_up, restart;
    logic [7:0]   addr;
    logic [31:0]  wdata, rdata, got;
    psk_phy_ctl_t ctl;
    int           error_cnt, n_compared, pulses, p0;
    logic         link_up_r, restart_r;
    psk_phy_ctl_t ctl_r;
    int           pulses_r, p0_r;

    psk_link_keeper psk_link_keeper_inst (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
        .addr_in(addr), .wr_data_in(wdata), .wr_en_in(wr_en), .rd_en_in(rd_en),
        .rd_data_out(rdata), .aux_power_in(aux), .link_up_in(link_up),
        .speed_100_in(spd), .phy_ctl_out(ctl), .autoneg_restart_out(restart));

    psk_phy_model psk_phy_model_inst (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
        .ctl_in(ctl), .restart_in(restart), .fail_in(fail), .link_up_out(link_up));

    // Second keeper built to renegotiate in D3, same bus and stimulus
    psk_link_keeper #(.D3_RETRY(1'b1)) psk_link_keeper_retry_inst (.ref_clk_in(ref_clk_in),
        .rst_in(rst_in), .addr_in(addr), .wr_data_in(wdata), .wr_en_in(wr_en),
        .rd_en_in(rd_en), .rd_data_out(), .aux_power_in(aux), .link_up_in(link_up_r),
        .speed_100_in(spd), .phy_ctl_out(ctl_r), .autoneg_restart_out(restart_r));

    psk_phy_model psk_phy_model_retry_inst (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
        .ctl_in(ctl_r), .restart_in(restart_r), .fail_in(fail), .link_up_out(link_up_r));

    // Clock, and restart pulses counted on the falling edge, clear of launch
    initial begin
        ref_clk_in = 1'b0;
        forever #50 ref_clk_in = ~ref_clk_in;
    end
    always @(negedge ref_clk_in) begin
        if (restart === 1'b1) pulses++;
        if (restart_r === 1'b1) pulses_r++;
    end

    task automatic check(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic check_ctl(input psk_phy_ctl_t g, input psk_phy_ctl_t e);
        check({28'h0, g}, {28'h0, e});
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge ref_clk_in);
        wr_en <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk_in);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk_in);
        rd_en <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic drop_link();
        @(posedge ref_clk_in);
        fail <= 1'b1;
        @(posedge ref_clk_in);
        fail <= 1'b0;
        repeat (4) @(posedge ref_clk_in);
        #1;
    endtask

    // Expected requests for a state, wake enable, aux power and speed
    function automatic psk_phy_ctl_t pol(input logic [1:0] s, input logic pe,
                                         input logic ax, input logic sp);
        logic k;
        k = (s != 2'h3) || (pe && ax);
        pol = '{link_keep: k, tx_idle_only: k && s != 2'h0 && sp,
                tx_silent: k && s != 2'h0 && !sp, deep_pd: 1'b0};
    endfunction

    task automatic final_report();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Watchdog
    initial begin
        #(100 * 2000);
        error_cnt++;
        final_report();
    end

    // Main sequence
    initial begin
        {wr_en, rd_en, aux, spd, fail} = 5'h0;
        addr = 8'h00;
        wdata = 32'h0;
        error_cnt = 0;
        n_compared = 0;
        pulses = 0;
        pulses_r = 0;
        rst_in = 1'b1;
        repeat (16) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        #1 check_ctl(ctl, PSK_PHY_CTL_RST);
        rd(PSK_STATUS_OFS, got);
        check(got, 32'h0000_0110);
        $display("reset test done");

        for (int i = 0; i < 16; i++) begin
            @(posedge ref_clk_in);
            aux <= i[3];
            spd <= i[1] ^ i[3];
            wr(PSK_CTRL_OFS, {29'h0, i[2:0]});
            check_ctl(ctl, pol(i[1:0], i[2], i[3], spd));
            check_ctl(ctl_r, pol(i[1:0], i[2], i[3], spd));
        end
        $display("policy table test done");

        @(posedge ref_clk_in);
        aux <= 1'b1;
        spd <= 1'b1;
        wr(PSK_CTRL_OFS, 32'h5);
        wr(PSK_STATUS_OFS, 32'hffff_ffff);
        check_ctl(ctl, pol(2'h1, 1'b1, 1'b1, 1'b1));
        rd(PSK_STATUS_OFS, got);
        check(got, 32'h0000_033d);
        @(posedge ref_clk_in);
        #1 check(rdata, 32'h0);
        rd(8'h08, got);
        check(got, 32'h0);
        rd(PSK_CTRL_OFS, got);
        check(got, 32'h0000_0005);
        $display("register test done");

        p0 = pulses;
        drop_link();
        check(pulses - p0, 1);
        repeat (10) @(posedge ref_clk_in);
        #1 check({31'h0, link_up}, 32'h1);
        $display("D1 failure test done");

        wr(PSK_CTRL_OFS, 32'h7);
        check_ctl(ctl, pol(2'h3, 1'b1, 1'b1, 1'b1));
        p0 = pulses;
        p0_r = pulses_r;
        drop_link();
        check_ctl(ctl, 4'b0001);
        check(pulses - p0, 0);
        check_ctl(ctl_r, pol(2'h3, 1'b1, 1'b1, 1'b1));
        check(pulses_r - p0_r, 1);
        repeat (6) @(posedge ref_clk_in);
        #1 check({31'h0, link_up_r}, 32'h1);
        check_ctl(ctl, 4'b0001);
        wr(PSK_CTRL_OFS, 32'h0);
        check_ctl(ctl, pol(2'h0, 1'b0, 1'b1, 1'b1));
        $display("D3 failure test done");
        final_report();
    end
endmodule

`default_nettype wire

// [dv/psk_phy_model.sv]
/*
 * Transceiver model standing at the far side of the link keeper.
 * Assumes requests from psk_link_keeper, all on ref_clk_in.
 */
`timescale 1ns/1ns
`default_nettype none

module psk_phy_model (
    input  wire logic                  ref_clk_in,
    input  wire logic                  rst_in,
    input  wire psk_pkg::psk_phy_ctl_t ctl_in,
    input  wire logic                  restart_in,
    input  wire logic                  fail_in,
    output logic                       link_up_out
);
    import psk_pkg::*;

    logic [3:0] wait_q;

    // Link drops on command, returns six cycles after a restart
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            link_up_out <= 1'b1;
            wait_q      <= 4'h0;
        end else if (fail_in) begin
            link_up_out <= 1'b0;
        end else if (restart_in && !ctl_in.deep_pd) begin
            wait_q      <= 4'h6;
        end else if (wait_q != 4'h0) begin
            wait_q      <= wait_q - 4'h1;
            link_up_out <= (wait_q == 4'h1);
        end
    end
endmodule

`default_nettype wire

// [logic/psk_link_keeper.sv]
/*
 * Power state link keeper: decides per power state whether the network
 * link is held, how the transmit pair behaves while held, and what a link
 * failure triggers (auto-negotiation restart or deep power-down).
 * Assumes all inputs are synchronous to ref_clk_in and a register master
 * that issues one-cycle strobes and takes read data the next cycle.
 */
// Our own choices: strobed register access and the register offsets.
//
// Functional notes
// - Four power states D0 to D3; D0 fully powered, D3 lowest.
// - In D0 the link is always kept active.
// - In D3 the link is kept only with wake enabled and auxiliary power.
// - In D3 the link drops if wake is disabled or auxiliary power absent.
// - Kept link at 10 Mbps in low power: receive normally, transmit nothing.
// - Kept link at 100 Mbps in low power: idle stream only, never frames.
// - Link failure in D1 restarts normal auto-negotiation.
// - Link failure in kept D3: retry negotiation or deep power-down, by build option.

`timescale 1ns/1ns
`default_nettype none

module psk_link_keeper #(
    parameter bit D3_RETRY = 1'b0     // 1: renegotiate in D3, 0: deep power-down
) (
    input  wire logic                  ref_clk_in,
    input  wire logic                  rst_in,
    // Register port
    input  wire logic [7:0]            addr_in,
    input  wire logic [31:0]           wr_data_in,
    input  wire logic                  wr_en_in,
    input  wire logic                  rd_en_in,
    output logic [31:0]                rd_data_out,
    // Platform and transceiver status
    input  wire logic                  aux_power_in,
    input  wire logic                  link_up_in,
    input  wire logic                  speed_100_in,
    // Requests to the transceiver
    output psk_pkg::psk_phy_ctl_t      phy_ctl_out,
    output logic                       autoneg_restart_out
);
    import psk_pkg::*;

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    psk_pwr_t     pwr_q;
    psk_pwr_t     pwr_d;
    logic         pme_q;
    logic         pme_d;
    logic         ctrl_wr;
    psk_phy_ctl_t ctl_q;
    psk_phy_ctl_t ctl_d;
    logic         link_prev_q;
    logic         link_fail;
    logic         autoneg_q;
    logic         autoneg_d;
    logic         dpd_set;
    logic         d3_hold;
    logic [31:0]  rd_data_q;
    logic [31:0]  rd_data_d;

    // Next control value, so the policy follows a write at the same edge
    assign ctrl_wr = wr_en_in && (addr_in == PSK_CTRL_OFS);
    assign pwr_d   = ctrl_wr ? psk_pwr_t'(wr_data_in[PSK_CTRL_PWR_LSB +: 2]) : pwr_q;
    assign pme_d   = ctrl_wr ? wr_data_in[PSK_CTRL_PME_BIT] : pme_q;

    // Power state and wake enable storage
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pwr_q <= psk_pwr_t'(PSK_PWR_RST);
            pme_q <= PSK_PME_RST;
        end else begin
            pwr_q <= pwr_d;
            pme_q <= pme_d;
        end
    end

    // ------------------------------------------------------------
    // Link failure detection
    // ------------------------------------------------------------
    // Failure counts only while the link is being held, so a link that
    // drops in deep power-down cannot start a renegotiation
    assign link_fail = link_prev_q && !link_up_in && ctl_q.link_keep;

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            link_prev_q <= 1'b0;
        end else begin
            link_prev_q <= link_up_in;
        end
    end

    // ------------------------------------------------------------
    // Link policy
    // ------------------------------------------------------------
    // D3 holds the link only with wake enabled and auxiliary power
    // Uses the enable being written, so the policy follows the write edge
    assign d3_hold = pme_d && aux_power_in;
    assign dpd_set = link_fail && (pwr_q == PSK_D3) && !D3_RETRY;

    always_comb begin
        ctl_d = '0;
        case (pwr_d)
            PSK_D0: begin
                ctl_d.link_keep = 1'b1;
            end
            PSK_D1,
            PSK_D2: begin
                ctl_d.link_keep = 1'b1;
            end
            PSK_D3: begin
                // Deep power-down stays until the D3 hold condition is lost
                ctl_d.deep_pd   = d3_hold && (dpd_set || ctl_q.deep_pd);
                ctl_d.link_keep = d3_hold && !ctl_d.deep_pd;
            end
            default: begin
                ctl_d.link_keep = 1'b0;
            end
        endcase
        // Low-power transmit behaviour depends on link speed
        if (ctl_d.link_keep && (pwr_d != PSK_D0)) begin
            ctl_d.tx_idle_only = speed_100_in;
            ctl_d.tx_silent    = !speed_100_in;
        end
    end

    // Restart negotiation on failure, except in D3 without retry
    assign autoneg_d = link_fail && ((pwr_q != PSK_D3) || D3_RETRY);

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctl_q     <= PSK_PHY_CTL_RST;
            autoneg_q <= 1'b0;
        end else begin
            ctl_q     <= ctl_d;
            autoneg_q <= autoneg_d;
        end
    end

    assign phy_ctl_out         = ctl_q;
    assign autoneg_restart_out = autoneg_q;

    // ------------------------------------------------------------
    // Register read
    // ------------------------------------------------------------
    // Unmapped offsets read as zero
    // Aux, link and speed status bits show the live pins of the strobe cycle
    always_comb begin
        rd_data_d = PSK_RDATA_RST;
        case (addr_in)
            PSK_CTRL_OFS: begin
                rd_data_d[PSK_CTRL_PWR_LSB +: 2] = pwr_q;
                rd_data_d[PSK_CTRL_PME_BIT]      = pme_q;
            end
            PSK_STATUS_OFS: begin
                rd_data_d[PSK_ST_PWR_LSB +: 2]   = pwr_q;
                rd_data_d[PSK_ST_PME_BIT]        = pme_q;
                rd_data_d[PSK_ST_AUX_BIT]        = aux_power_in;
                rd_data_d[PSK_ST_KEEP_BIT]       = ctl_q.link_keep;
                rd_data_d[PSK_ST_IDLE_BIT]       = ctl_q.tx_idle_only;
                rd_data_d[PSK_ST_SILENT_BIT]     = ctl_q.tx_silent;
                rd_data_d[PSK_ST_DPD_BIT]        = ctl_q.deep_pd;
                rd_data_d[PSK_ST_LINK_BIT]       = link_up_in;
                rd_data_d[PSK_ST_SPD_BIT]        = speed_100_in;
            end
            default: begin
                rd_data_d = PSK_RDATA_RST;
            end
        endcase
    end

    // Read data stand one cycle after the strobe only
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rd_data_q <= PSK_RDATA_RST;
        end else if (rd_en_in) begin
            rd_data_q <= rd_data_d;
        end else begin
            rd_data_q <= PSK_RDATA_RST;
        end
    end

    assign rd_data_out = rd_data_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    sequence s_fail_in_d1;
        (pwr_q == PSK_D1) && link_fail;
    endsequence

    sequence s_fail_in_d3;
        (pwr_q == PSK_D3) && link_fail && d3_hold && (pwr_d == PSK_D3);
    endsequence

    chk_deep_pd_d3: assert property (phy_ctl_out.deep_pd |-> (pwr_q == PSK_D3))
        else $error("deep power-down outside D3");

    chk_d0_link_kept: assert property ((pwr_d == PSK_D0) |=> phy_ctl_out.link_keep)
        else $error("link not kept in D0");

    chk_d3_link_kept: assert property (
        (pwr_d == PSK_D3) && pme_d && aux_power_in && !ctl_q.deep_pd && !dpd_set
        |=> phy_ctl_out.link_keep)
        else $error("link not kept in enabled D3");

    chk_d3_link_drop: assert property (
        (pwr_d == PSK_D3) && !(pme_d && aux_power_in)
        |=> !phy_ctl_out.link_keep && !phy_ctl_out.deep_pd)
        else $error("link kept in D3 without wake or power");

    chk_ten_tx_quiet: assert property (
        phy_ctl_out.link_keep && (pwr_q != PSK_D0) && !$past(speed_100_in)
        |-> phy_ctl_out.tx_silent && !phy_ctl_out.tx_idle_only)
        else $error("10 Mbps low-power transmit not quiet");

    chk_hundred_idle: assert property (
        phy_ctl_out.link_keep && (pwr_q != PSK_D0) && $past(speed_100_in)
        |-> phy_ctl_out.tx_idle_only && !phy_ctl_out.tx_silent)
        else $error("100 Mbps low-power transmit not idle-only");

    chk_d1_renegotiate: assert property (
        s_fail_in_d1 |=> autoneg_restart_out ##1 !autoneg_restart_out)
        else $error("no single restart after D1 link failure");

    chk_d3_fail_action: assert property (
        s_fail_in_d3 |=>
        (D3_RETRY ? (autoneg_restart_out && !phy_ctl_out.deep_pd)
                  : (phy_ctl_out.deep_pd && !autoneg_restart_out
                     && !phy_ctl_out.link_keep)))
        else $error("wrong action after D3 link failure");

    chk_state_write: assert property (
        ctrl_wr |=> (pwr_q == $past(wr_data_in[PSK_CTRL_PWR_LSB +: 2]))
                    && (pme_q == $past(wr_data_in[PSK_CTRL_PME_BIT])))
        else $error("power state write not applied next clock");

    // ------------------------------------------------------------
    // Further policy and register checks
    // ------------------------------------------------------------
    // Deep power-down with the hold condition intact
    sequence s_dpd_held;
        phy_ctl_out.deep_pd && (pwr_d == PSK_D3) && d3_hold;
    endsequence

    // Read strobe on the control register
    sequence s_ctrl_read;
        rd_en_in && (addr_in == PSK_CTRL_OFS);
    endsequence

    // Read strobe on the status register
    sequence s_status_read;
        rd_en_in && (addr_in == PSK_STATUS_OFS);
    endsequence

    // Full power transmits freely
    chk_d0_tx_normal: assert property ((pwr_d == PSK_D0) |=>
        !phy_ctl_out.tx_idle_only && !phy_ctl_out.tx_silent && !phy_ctl_out.deep_pd)
        else $error("transmit restricted in D0");

    chk_low_pwr_kept: assert property (
        ((pwr_d == PSK_D1) || (pwr_d == PSK_D2)) |=> phy_ctl_out.link_keep)
        else $error("link not kept in D1 or D2");

    // Transmit restrictions are exclusive and ride on a held link
    chk_tx_mode_excl: assert property (
        !(phy_ctl_out.tx_idle_only && phy_ctl_out.tx_silent))
        else $error("idle-only and quiet transmit at once");

    chk_tx_mode_kept: assert property (
        (phy_ctl_out.tx_idle_only || phy_ctl_out.tx_silent) |-> phy_ctl_out.link_keep)
        else $error("transmit restriction without held link");

    chk_no_stray_restart: assert property (!link_fail |=> !autoneg_restart_out)
        else $error("restart without link failure");

    chk_dpd_sticky: assert property (s_dpd_held |=> phy_ctl_out.deep_pd)
        else $error("deep power-down left while D3 held");

    chk_dpd_no_keep: assert property (
        phy_ctl_out.deep_pd
        |-> !phy_ctl_out.link_keep && !autoneg_restart_out)
        else $error("link held or retried in deep power-down");

    // Read data only in the cycle after the strobe
    chk_rd_idle_zero: assert property (!rd_en_in |=> (rd_data_out == PSK_RDATA_RST))
        else $error("read data outside the read cycle");

    chk_ctrl_readback: assert property (
        s_ctrl_read |=> (rd_data_out[PSK_CTRL_PWR_LSB +: 2] == $past(pwr_q))
                        && (rd_data_out[PSK_CTRL_PME_BIT] == $past(pme_q)))
        else $error("control readback differs from stored state");

    chk_status_policy: assert property (
        s_status_read |=> (rd_data_out[PSK_ST_KEEP_BIT] == $past(ctl_q.link_keep))
                          && (rd_data_out[PSK_ST_DPD_BIT] == $past(ctl_q.deep_pd)))
        else $error("status read does not show the link policy");

    chk_unmapped_zero: assert property (
        rd_en_in && (addr_in != PSK_CTRL_OFS) && (addr_in != PSK_STATUS_OFS)
        |=> (rd_data_out == PSK_RDATA_RST))
        else $error("unmapped offset read non-zero");

endmodule

`default_nettype wire

// [logic/psk_pkg.sv]
/*
 * Package for the power state link keeper: register offsets, field
 * positions, reset values and the carrier types shared with the bench.
 * Assumes a plain register port with 32-bit data and byte addresses.
 */
`default_nettype none

package psk_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0]  PSK_CTRL_OFS      = 8'h00;  // Power state and wake enable
    localparam logic [7:0]  PSK_STATUS_OFS    = 8'h04;  // Link policy state, read only

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int          PSK_CTRL_PWR_LSB  = 0;      // Power state, two bits
    localparam int          PSK_CTRL_PME_BIT  = 2;      // Wake signalling enable
    localparam int          PSK_ST_PWR_LSB    = 0;      // Applied power state
    localparam int          PSK_ST_PME_BIT    = 2;
    localparam int          PSK_ST_AUX_BIT    = 3;      // Auxiliary power present
    localparam int          PSK_ST_KEEP_BIT   = 4;      // Link being maintained
    localparam int          PSK_ST_IDLE_BIT   = 5;      // Idle-only transmit
    localparam int          PSK_ST_SILENT_BIT = 6;      // Transmit pair quiet
    localparam int          PSK_ST_DPD_BIT    = 7;      // Deep power-down
    localparam int          PSK_ST_LINK_BIT   = 8;      // Link up from the transceiver
    localparam int          PSK_ST_SPD_BIT    = 9;      // 100 Mbps link

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [1:0]  PSK_PWR_RST       = 2'h0;   // Start fully powered
    localparam logic        PSK_PME_RST       = 1'b0;
    localparam logic [31:0] PSK_RDATA_RST     = 32'h0000_0000;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    // Power states in order of falling power, codes 00 to 11
    typedef enum logic [1:0] {
        PSK_D0,
        PSK_D1,
        PSK_D2,
        PSK_D3
    } psk_pwr_t;

    // Requests to the physical layer, all from flip-flops
    typedef struct packed {
        logic link_keep;      // Hold the link up
        logic tx_idle_only;   // 100 Mbps: idle stream only, no frames
        logic tx_silent;      // 10 Mbps: drive nothing on the transmit pair
        logic deep_pd;        // Deep power-down
    } psk_phy_ctl_t;

    localparam psk_phy_ctl_t PSK_PHY_CTL_RST  = '{link_keep: 1'b1, tx_idle_only: 1'b0,
                                                  tx_silent: 1'b0, deep_pd: 1'b0};

endpackage

`default_nettype wire
